// *** rtl/celse_encoder.sv ***
// error code to indicator pattern and run permission encoder
// Contract
// (R1) the indicator shows one of five patterns: on, off, fast, normal, slow.
// (R2) fast blink toggles every 0.2 s for supply or hardware trouble.
// (R3) normal blink toggles every 0.5 s for program errors or no-run states.
// (R4) slow blink lights one second then stays dark three seconds, repeating.
// (R5) scan timeout drives the indicator steadily on and stops the cpu.
// (R6) while on, fast or normal, run is refused until the error is cleared.
// (R7) each code carries a stop or continue action for the cpu.
// (R8) damaged program or denied memory access stops the cpu in normal blink.
// (R9) program and log mismatch stops the cpu in normal blink.
// (R10) bad id, bad password or too many tries continue with indicator off.
// (R11) abnormal retained memories continue with indicator off.
// (R12) a short supply dip continues with fast blink.
// (R13) clock loss and low battery continue, no pattern, battery indicator.
// (R14) off-class warnings stay visible in flag relays and data registers.
// (R15) slow warnings need no immediate action; the operator clears them; no error code sets sev_slow here, so slow blink never shows.
// (R16) with several errors the most severe pattern is shown.
// (R17) blink timing comes from reset-aligned clock prescalers.
`timescale 1ns/100ps
module celse_encoder (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // error report from fault detectors
   input wire logic i_err_valid,
   input wire logic [15:0] i_err_code,
   input wire logic i_err_clear,
   // run control
   input wire logic i_run_req,
   output logic o_cpu_run,
   output logic o_stop_evt,
   // indicators
   output logic o_err_led,
   output logic [2:0] o_led_pattern,
   output logic o_batt_led,
   output logic o_batt_blink,
   // warnings exposed to the user program
   output logic o_special_flag_relays,
   output logic [15:0] o_special_data_regs
);
   typedef struct packed {
      logic run;
      logic stop_evt;
      logic sev_on;
      logic sev_fast;
      logic sev_norm;
      logic sev_slow;
      logic warn_off;
      logic [15:0] last_warn;
      logic rtc_loss;
      logic batt_low;
      logic fast_ph;
      logic norm_ph;
      logic [1:0] slow_step;
      logic led;
      logic [2:0] pat;
   } celse_st_t;

   celse_st_t st_reg;
   celse_st_t st_next;
   logic tick_fast;
   logic tick_norm;
   logic tick_slow;
   // per-code decode results
   logic d_on;
   logic d_fast;
   logic d_norm;
   logic d_off;
   logic d_stop;
   logic d_rtc;
   logic d_batt;
   celse_pkg::celse_pat_t pat_sel;
   logic run_blocked;

   // prescalers for the three blink steps
   celse_tick #(.PERIOD(celse_pkg::FAST_CYC)) u_tick_fast (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .o_tick(tick_fast)
   ); // [R17]
   celse_tick #(.PERIOD(celse_pkg::NORM_CYC)) u_tick_norm (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .o_tick(tick_norm)
   ); // [R17]
   celse_tick #(.PERIOD(celse_pkg::SLOW_CYC)) u_tick_slow (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .o_tick(tick_slow)
   ); // [R17]

   // code decode; unknown codes are ignored rather than guessed
   always_comb begin
      d_on = 1'b0;
      d_fast = 1'b0;
      d_norm = 1'b0;
      d_off = 1'b0;
      d_stop = 1'b0;
      d_rtc = 1'b0;
      d_batt = 1'b0;
      case (i_err_code)
         celse_pkg::EC_SCAN_TMO: begin
            d_on = 1'b1; // [R5]
            d_stop = 1'b1; // [R7]
         end
         celse_pkg::EC_PROG_DMG, celse_pkg::EC_INT_MEM,
         celse_pkg::EC_EXT_MEM: begin
            d_norm = 1'b1; // [R8]
            d_stop = 1'b1; // [R8]
         end
         celse_pkg::EC_LOG_MISM: begin
            d_norm = 1'b1; // [R9]
            d_stop = 1'b1; // [R9]
         end
         celse_pkg::EC_BAD_ID, celse_pkg::EC_BAD_PWD,
         celse_pkg::EC_PWD_TRIES: begin
            d_off = 1'b1; // [R10]
         end
         celse_pkg::EC_RET_SAUX, celse_pkg::EC_RET_SDREG,
         celse_pkg::EC_RET_AUX, celse_pkg::EC_RET_CNT,
         celse_pkg::EC_RET_CNT32: begin
            d_off = 1'b1; // [R11]
         end
         celse_pkg::EC_SUPPLY_DIP: begin
            d_fast = 1'b1; // [R12]
         end
         celse_pkg::EC_RTC_LOSS: begin
            d_rtc = 1'b1; // [R13]
         end
         celse_pkg::EC_BATT_LOW: begin
            d_batt = 1'b1; // [R13]
         end
         default: begin
            d_stop = 1'b0;
         end
      endcase
   end

   // severity priority: on, fast, normal, slow, off
   always_comb begin
      if (st_reg.sev_on) begin
         pat_sel = celse_pkg::CELSE_PAT_ON; // [R16]
      end else if (st_reg.sev_fast) begin
         pat_sel = celse_pkg::CELSE_PAT_FAST; // [R16]
      end else if (st_reg.sev_norm) begin
         pat_sel = celse_pkg::CELSE_PAT_NORM; // [R16]
      end else if (st_reg.sev_slow) begin
         pat_sel = celse_pkg::CELSE_PAT_SLOW; // [R16]
      end else begin
         pat_sel = celse_pkg::CELSE_PAT_OFF; // [R16]
      end
   end

   // on, fast and normal refuse a new run grant until cleared
   assign run_blocked = st_reg.sev_on | st_reg.sev_fast
      | st_reg.sev_norm; // [R6]

   always_comb begin
      st_next = st_reg;
      st_next.stop_evt = 1'b0;
      // clear first so a code arriving with the clear is kept
      if (i_err_clear) begin
         st_next.sev_on = 1'b0;
         st_next.sev_fast = 1'b0;
         st_next.sev_norm = 1'b0;
         st_next.sev_slow = 1'b0;
         st_next.warn_off = 1'b0;
         st_next.rtc_loss = 1'b0;
         st_next.batt_low = 1'b0;
      end
      if (i_err_valid) begin
         st_next.sev_on = st_next.sev_on | d_on;
         st_next.sev_fast = st_next.sev_fast | d_fast;
         st_next.sev_norm = st_next.sev_norm | d_norm;
         st_next.rtc_loss = st_next.rtc_loss | d_rtc;
         st_next.batt_low = st_next.batt_low | d_batt;
         if (d_off) begin
            st_next.warn_off = 1'b1; // [R14]
            st_next.last_warn = i_err_code; // [R14]
         end
      end
      // stop action halts execution at once [R7]
      if (i_err_valid && d_stop) begin
         st_next.run = 1'b0;
         st_next.stop_evt = st_reg.run;
      end else if (i_run_req && !run_blocked) begin
         // a running cpu rides through a dip; only a new grant waits [R12]
         st_next.run = 1'b1; // [R6]
      end
      // blink phases
      if (tick_fast) begin
         st_next.fast_ph = ~st_reg.fast_ph; // [R2]
      end
      if (tick_norm) begin
         st_next.norm_ph = ~st_reg.norm_ph; // [R3]
      end
      if (tick_slow) begin
         if (st_reg.slow_step == 2'(celse_pkg::SLOW_DARK_STEPS)) begin
            st_next.slow_step = '0; // [R4]
         end else begin
            st_next.slow_step = st_reg.slow_step + 1'b1; // [R4]
         end
      end
      st_next.pat = pat_sel;
      case (pat_sel)
         celse_pkg::CELSE_PAT_ON: st_next.led = 1'b1; // [R5]
         celse_pkg::CELSE_PAT_FAST: st_next.led = st_reg.fast_ph; // [R2]
         celse_pkg::CELSE_PAT_NORM: st_next.led = st_reg.norm_ph; // [R3]
         celse_pkg::CELSE_PAT_SLOW:
            st_next.led = (st_reg.slow_step == 2'h0); // [R4]
         celse_pkg::CELSE_PAT_OFF: st_next.led = 1'b0; // [R1]
         default: st_next.led = 1'b0;
      endcase
   end

   // single state register, cpu stopped and dark after reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= '0;
         st_reg.pat <= celse_pkg::CELSE_PAT_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_cpu_run = st_reg.run;
   assign o_stop_evt = st_reg.stop_evt;
   assign o_err_led = st_reg.led;
   assign o_led_pattern = st_reg.pat;
   assign o_batt_led = st_reg.batt_low; // [R13]
   assign o_batt_blink = st_reg.rtc_loss; // [R13]
   assign o_special_flag_relays = st_reg.warn_off; // [R14]
   assign o_special_data_regs = st_reg.last_warn; // [R14]

   // checks: run permission
   a_on_blocks_run: assert property ( // [R6]
      @(posedge i_clk) disable iff (!i_rst_n)
      st_reg.sev_on |=> !o_cpu_run)
      else $error("cpu runs while indicator on");
   a_run_refused: assert property ( // [R6]
      @(posedge i_clk) disable iff (!i_rst_n)
      run_blocked && !o_cpu_run |=> !o_cpu_run)
      else $error("run granted while error latched");
   a_stop_pulse: assert property ( // [R7]
      @(posedge i_clk) disable iff (!i_rst_n)
      o_stop_evt |-> !o_cpu_run)
      else $error("halt pulse with cpu running");
   // checks: code classes
   a_scan_stops: assert property ( // [R5]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && i_err_code == celse_pkg::EC_SCAN_TMO
      |=> !o_cpu_run ##1 o_led_pattern == celse_pkg::CELSE_PAT_ON)
      else $error("scan timeout not stopping");
   a_norm_codes: assert property ( // [R8] [R9]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && !i_err_clear
      && (i_err_code == celse_pkg::EC_LOG_MISM
      || i_err_code == celse_pkg::EC_PROG_DMG
      || i_err_code == celse_pkg::EC_INT_MEM
      || i_err_code == celse_pkg::EC_EXT_MEM)
      |=> !o_cpu_run ##1 o_led_pattern <= celse_pkg::CELSE_PAT_NORM)
      else $error("normal-blink code mishandled");
   a_off_codes: assert property ( // [R10]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && !i_err_clear && !run_blocked && o_cpu_run
      && i_err_code == celse_pkg::EC_BAD_PWD
      |=> o_cpu_run && o_special_flag_relays)
      else $error("off-class code stopped cpu");
   a_dip_fast: assert property ( // [R12]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && !i_err_clear && !st_reg.sev_on
      && i_err_code == celse_pkg::EC_SUPPLY_DIP
      |=> ##1 o_led_pattern == celse_pkg::CELSE_PAT_FAST)
      else $error("supply dip not fast blink");
   a_dip_runs: assert property ( // [R12]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && i_err_code == celse_pkg::EC_SUPPLY_DIP && o_cpu_run
      |=> o_cpu_run)
      else $error("supply dip stopped cpu");
   a_batt_led: assert property ( // [R13]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && !i_err_clear && i_err_code == celse_pkg::EC_BATT_LOW
      |=> o_batt_led)
      else $error("battery indicator not lit");
   a_rtc_blink: assert property ( // [R13]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_err_valid && i_err_code == celse_pkg::EC_RTC_LOSS
      |=> o_batt_blink)
      else $error("battery blink not set on clock loss");
   // checks: indicator drive
   a_on_steady: assert property ( // [R5]
      @(posedge i_clk) disable iff (!i_rst_n)
      o_led_pattern == celse_pkg::CELSE_PAT_ON
      && $past(pat_sel) == celse_pkg::CELSE_PAT_ON |-> o_err_led)
      else $error("on pattern not lit");
   a_off_dark: assert property ( // [R1]
      @(posedge i_clk) disable iff (!i_rst_n)
      o_led_pattern == celse_pkg::CELSE_PAT_OFF |-> !o_err_led)
      else $error("off pattern lit");
   a_fast_toggle: assert property ( // [R2]
      @(posedge i_clk) disable iff (!i_rst_n)
      tick_fast |=> st_reg.fast_ph != $past(st_reg.fast_ph))
      else $error("fast phase did not toggle");
endmodule

// *** rtl/celse_pkg.sv ***
// package: error codes, indicator patterns and blink timing for the encoder
package celse_pkg;
   // clock
   localparam int unsigned CLK_HZ = 25000000;
   // blink steps in milliseconds
   localparam int unsigned FAST_MS = 200;
   localparam int unsigned NORM_MS = 500;
   localparam int unsigned SLOW_MS = 1000;
   // slow pattern: one lit second then dark for three
   localparam int unsigned SLOW_DARK_STEPS = 3;
   localparam int unsigned SLOW_CYCLE_STEPS = SLOW_DARK_STEPS + 1;
   // derived cycle counts
   localparam int unsigned FAST_CYC = CLK_HZ / 1000 * FAST_MS;
   localparam int unsigned NORM_CYC = CLK_HZ / 1000 * NORM_MS;
   localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
   localparam int unsigned CNT_W = 25;
   localparam int unsigned CODE_W = 16;
   // error codes
   localparam logic [15:0] EC_SCAN_TMO = 16'h000a;
   localparam logic [15:0] EC_PROG_DMG = 16'h000c;
   localparam logic [15:0] EC_INT_MEM = 16'h0010;
   localparam logic [15:0] EC_BAD_ID = 16'h0011;
   localparam logic [15:0] EC_BAD_PWD = 16'h0012;
   localparam logic [15:0] EC_RTC_LOSS = 16'h0026;
   localparam logic [15:0] EC_BATT_LOW = 16'h0027;
   localparam logic [15:0] EC_SUPPLY_DIP = 16'h002a;
   localparam logic [15:0] EC_PWD_TRIES = 16'h002d;
   localparam logic [15:0] EC_EXT_MEM = 16'h002e;
   localparam logic [15:0] EC_LOG_MISM = 16'h002f;
   localparam logic [15:0] EC_RET_SAUX = 16'h0050;
   localparam logic [15:0] EC_RET_SDREG = 16'h0051;
   localparam logic [15:0] EC_RET_AUX = 16'h0052;
   localparam logic [15:0] EC_RET_CNT = 16'h0054;
   localparam logic [15:0] EC_RET_CNT32 = 16'h0055;
   // indicator patterns; lower code is more severe
   typedef enum logic [2:0] {
      CELSE_PAT_ON = 3'b000,
      CELSE_PAT_FAST = 3'b001,
      CELSE_PAT_NORM = 3'b010,
      CELSE_PAT_SLOW = 3'b011,
      CELSE_PAT_OFF = 3'b100
   } celse_pat_t;
endpackage

// *** rtl/celse_tick.sv ***
// tick prescaler: one-cycle pulse every PERIOD clocks
`timescale 1ns/100ps
module celse_tick #(
   parameter int unsigned PERIOD = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // tick
   output logic o_tick
);
   typedef struct packed {
      logic [celse_pkg::CNT_W-1:0] cnt;
      logic tick;
   } celse_tick_st_t;
   localparam logic [celse_pkg::CNT_W-1:0] LAST =
      celse_pkg::CNT_W'(PERIOD - 1);
   celse_tick_st_t st_reg;
   celse_tick_st_t st_next;

   // count up to the period edge, restart from zero
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == LAST) begin
         st_next.cnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // restart on reset so all ticks line up [R17]
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_tick = st_reg.tick;
endmodule

// *** tb/celse_panel_model.sv ***
// panel model: run switch and halt counter facing the encoder
`timescale 1ns/100ps
module celse_panel_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // operator side
   input wire logic i_want_run,
   // from the encoder
   input wire logic i_stop_evt,
   // run switch level and halts seen
   output logic o_run_req,
   output int o_stop_cnt
);
   // switch moves just after the edge; slow warnings are left to the
   // operator, so the model never clears anything itself
   always @(posedge i_clk) begin
      o_run_req <= #1 i_want_run & i_rst_n;
   end
   // count halt pulses as the run control would latch them
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_stop_cnt <= 0;
      end else if (i_stop_evt === 1'b1) begin
         o_stop_cnt <= o_stop_cnt + 1;
      end
   end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the error indicator encoder
`timescale 1ns/100ps
module testbench;
   typedef struct {
      logic [2:0] pat;
      logic run;
      logic stop;
      logic flag;
      logic [15:0] regs;
      logic bl;
      logic bb;
   } celse_exp_t;
   logic i_clk, i_rst_n, i_err_valid, i_err_clear, want_run, run_req;
   logic o_cpu_run, o_stop_evt, o_err_led, o_batt_led, o_batt_blink;
   logic o_special_flag_relays;
   logic [2:0] o_led_pattern;
   logic [15:0] i_err_code, o_special_data_regs;
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 16;
   int stops = 0;
   int stop_cnt, j, k;
   logic [1:0] sh = 2'h0;
   celse_exp_t q[$];
   celse_exp_t e, h;
   // code table with pattern, stop mask and off-class mask
   logic [15:0] codes [16] = '{16'h000a, 16'h000c, 16'h0010, 16'h0011,
      16'h0012, 16'h0026, 16'h0027, 16'h002a, 16'h002d, 16'h002e, 16'h002f,
      16'h0050, 16'h0051, 16'h0052, 16'h0054, 16'h0055};
   logic [2:0] pats [16] = '{3'h0, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4,
      3'h1, 3'h4, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
   logic [15:0] stopm = 16'h0607;
   logic [15:0] offm = 16'hf918;

   celse_encoder dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_err_valid(i_err_valid), .i_err_code(i_err_code),
      .i_err_clear(i_err_clear), .i_run_req(run_req),
      .o_cpu_run(o_cpu_run), .o_stop_evt(o_stop_evt), .o_err_led(o_err_led),
      .o_led_pattern(o_led_pattern), .o_batt_led(o_batt_led),
      .o_batt_blink(o_batt_blink),
      .o_special_flag_relays(o_special_flag_relays),
      .o_special_data_regs(o_special_data_regs));
   celse_panel_model panel_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_want_run(want_run), .i_stop_evt(o_stop_evt), .o_run_req(run_req),
      .o_stop_cnt(stop_cnt));

   // 25 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic idle(input int n);
      i_err_valid = 1'b0;
      tick(n);
   endtask

   // clear everything, then the held run request must be granted again
   task automatic clear_all();
      i_err_clear = 1'b1;
      tick(1);
      i_err_clear = 1'b0;
      h = '{3'h4, 1'b1, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0};
      tick(5);
      chk(o_cpu_run, 1'b1);
   endtask

   // valid is left high so reports can run back to back
   task automatic report(input logic [15:0] c, input logic [2:0] p,
         input logic st, input logic off);
      i_err_valid = 1'b1;
      i_err_code = c;
      if (p < h.pat) h.pat = p;
      // continue-class codes, fast blink included, leave run as it was
      h.stop = st & h.run;
      if (st & h.run) stops++;
      h.run = h.run & ~st;
      if (off) begin
         h.flag = 1'b1;
         h.regs = c;
      end
      h.bb |= (c == 16'h0026);
      h.bl |= (c == 16'h0027);
      q.push_back(h);
      tick(1);
   endtask

   // run and flags land one cycle after a report, the pattern two
   always @(posedge i_clk) begin
      sh <= {sh[0], i_err_valid & i_rst_n};
      if (sh[1]) begin
         e = q.pop_front();
         chk(o_led_pattern, e.pat);
         if (e.pat == 3'h0 || e.pat == 3'h4) begin
            chk(o_err_led, e.pat == 3'h0);
         end
      end
      if (sh[0] && q.size() > 0) begin
         e = q[0];
         chk({o_cpu_run, o_stop_evt}, {e.run, e.stop});
         chk(o_special_flag_relays, e.flag);
         if (e.flag) chk(o_special_data_regs, e.regs);
         chk({o_batt_led, o_batt_blink}, {e.bl, e.bb});
      end
   end

   task automatic final_report();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #(40 * 20000);
      error_cnt++;
      final_report();
   end

   initial begin
      i_rst_n = 1'b0;
      i_err_valid = 1'b0;
      i_err_clear = 1'b0;
      i_err_code = 16'h0000;
      want_run = 1'b1;
      tick(4);
      i_rst_n = 1'b1;
      chk({o_cpu_run, o_led_pattern}, 4'h4);
      // every code alone, stop codes must keep run refused
      for (int i = 0; i < 16; i++) begin
         clear_all();
         report(codes[i], pats[i], stopm[i], offm[i]);
         idle(12);
         if (stopm[i]) chk(o_cpu_run, 1'b0);
         else chk(o_cpu_run, 1'b1);
      end
      // rising severity back to back
      clear_all();
      report(16'h0011, 3'h4, 1'b0, 1'b1);
      report(16'h000c, 3'h2, 1'b1, 1'b0);
      report(16'h002a, 3'h1, 1'b0, 1'b0);
      report(16'h000a, 3'h0, 1'b1, 1'b0);
      idle(6);
      // random pairs around an unknown code that must be ignored
      repeat (20) begin
         clear_all();
         j = $unsigned($random(seed)) % 16;
         k = $unsigned($random(seed)) % 16;
         report(codes[j], pats[j], stopm[j], offm[j]);
         report({4'h9, 12'($random(seed))}, 3'h4, 1'b0, 1'b0);
         report(codes[k], pats[k], stopm[k], offm[k]);
         idle(6);
      end
      chk(16'(stop_cnt), 16'(stops));
      final_report();
   end
endmodule
